/* File: hw/sfb_flash_dev.sv */
// Operation
// - page read wraps within same page
// - chip select rise ends read, releases output
// - page read bypasses buffer, buffer untouched
// - two buffer read opcodes behave alike
// - buffer read never touches the array
// - buffer address holds 9 or 8 offset bits
// - buffer read data after one dummy byte
// - buffer read wraps to offset zero
// - host keeps select low whole read
// - buffer write stores bytes at consecutive offsets
// - buffer write wraps, continues until select rises
// - program with erase: erase, then program
// - page number sits below leading ignored bits
// - program without erase leaves page unerased
// - host erases page before plain program
// - page erase sets every bit to one
// - block erase clears eight pages
// - block number from top six page bits
// - busy shown while self-timed operation runs
// - page read data after four dummy bytes
`timescale 1ns/1ps
`default_nettype none
`include "sfb_map.svh"
module sfb_flash_dev
   import sfb_pkg::*;
#(
   parameter int PAGES      = `SFB_PAGES,
   parameter int PAGE_BYTES = `SFB_PAGE_BYTES,
   parameter int EP_CYC     = `SFB_EP_CYC,
   parameter int P_CYC      = `SFB_P_CYC,
   parameter int PE_CYC     = `SFB_PE_CYC,
   parameter int BE_CYC     = `SFB_BE_CYC
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic page_256,
   sfb_spi_if.dev    spi,
   output logic      busy
);
   localparam int MW = $clog2(PAGES * PAGE_BYTES);
   generate
      if (PAGES != `SFB_PAGES || PAGE_BYTES < 257 || PAGE_BYTES > 512) begin : g_bad
         $error("sfb_flash_dev: geometry not supported");
      end
   endgenerate
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [1:0] cs_q;
   logic [1:0] sck_q;
   logic [1:0] si_q;
   logic [1:0] mode_q;
   logic       cs_prev_r;
   logic       sck_prev_r;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cs_q       <= 2'h3;
         sck_q      <= 2'h0;
         si_q       <= 2'h0;
         mode_q     <= 2'h0;
         cs_prev_r  <= 1'b1;
         sck_prev_r <= 1'b0;
      end else begin
         cs_q       <= {cs_q[0], spi.cs_n};
         sck_q      <= {sck_q[0], spi.sck};
         si_q       <= {si_q[0], spi.si};
         mode_q     <= {mode_q[0], page_256};
         cs_prev_r  <= cs_q[1];
         sck_prev_r <= sck_q[1];
      end
   end
   logic sel;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   assign sel      = ~cs_q[1];
   // Clock level between frames is irrelevant: only edges inside the frame count
   assign sck_rise = sel & sck_q[1] & ~sck_prev_r;
   assign sck_fall = sel & ~sck_q[1] & sck_prev_r;
   assign cs_rise  = cs_q[1] & ~cs_prev_r;
   // ****************************************
   // Address decode helpers
   // ****************************************
   function automatic logic [8:0] page_of(input logic [23:0] a, input logic bin);
      page_of = bin ? a[16:8] : a[17:9];
   endfunction
   function automatic logic [8:0] offset_of(input logic [23:0] a, input logic bin);
      offset_of = bin ? {1'b0, a[7:0]} : a[8:0];
   endfunction
   function automatic logic [8:0] next_off(input logic [8:0] o, input logic bin);
      logic [8:0] last;
      last     = bin ? `SFB_BIN_LAST : 9'(PAGE_BYTES - 1);
      next_off = (o == last) ? 9'h000 : o + 9'h001;
   endfunction
   function automatic logic [MW-1:0] mem_idx(input logic [8:0] pg, input int off);
      mem_idx = MW'(int'(pg) * PAGE_BYTES + off);
   endfunction
   // ****************************************
   // Command shifter
   // ****************************************
   logic [2:0]  bit_r;
   logic [3:0]  byte_idx_r;
   logic [7:0]  sh_r;
   logic [7:0]  op_r;
   logic [23:0] addr_r;
   logic [7:0]  sh_nxt;
   logic        byte_done;
   assign sh_nxt    = {sh_r[6:0], si_q[1]};
   assign byte_done = sck_rise & (bit_r == 3'h7);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bit_r      <= 3'h0;
         byte_idx_r <= 4'h0;
         sh_r       <= 8'h00;
         op_r       <= 8'h00;
         addr_r     <= 24'h000000;
      end else if (!sel) begin
         bit_r      <= 3'h0;
         byte_idx_r <= 4'h0;
      end else if (sck_rise) begin
         sh_r  <= sh_nxt;
         bit_r <= bit_r + 3'h1;
         if (bit_r == 3'h7) begin
            if (byte_idx_r != 4'hf) begin
               byte_idx_r <= byte_idx_r + 4'h1;
            end
            if (byte_idx_r == 4'h0) begin
               op_r <= sh_nxt;
            end
            if (byte_idx_r != 4'h0 && byte_idx_r < `SFB_ADDR_DONE) begin
               addr_r <= {addr_r[15:0], sh_nxt};
            end
         end
      end
   end
   logic is_page_rd;
   logic is_buf_rd;
   logic is_buf_wr;
   logic rd_phase;
   logic wr_byte;
   logic addr_last;
   logic [23:0] addr_full;
   assign is_page_rd = op_r == `SFB_OP_PAGE_READ;
   assign is_buf_rd  = op_r == `SFB_OP_BUF_READ_FAST ||
                       op_r == `SFB_OP_BUF_READ_SLOW;
   assign is_buf_wr  = op_r == `SFB_OP_BUF_WRITE;
   assign rd_phase   = sel & ((is_page_rd & byte_idx_r >= `SFB_PR_DATA) |
                              (is_buf_rd & byte_idx_r >= `SFB_BR_DATA));
   // Buffer is locked while a program reads it out
   assign wr_byte    = byte_done & is_buf_wr & (byte_idx_r >= `SFB_ADDR_DONE) & ~busy;
   assign addr_last  = byte_done & (byte_idx_r == `SFB_ADDR_DONE - 4'h1);
   assign addr_full  = {addr_r[15:0], sh_nxt};
   // ****************************************
   // Pointer, buffer and output shifter
   // ****************************************
   logic [7:0] buf_mem [PAGE_BYTES];
   logic [7:0] arr_mem [PAGES * PAGE_BYTES];
   logic [8:0] ptr_r;
   logic [8:0] pg_r;
   logic [7:0] tx_r;
   logic [7:0] rd_byte;
   logic       load_tx;
   assign load_tx = sck_fall & rd_phase & (bit_r == 3'h0);
   // Page read goes straight to the array, buffer read straight to SRAM
   assign rd_byte = is_page_rd ? arr_mem[mem_idx(pg_r, int'(ptr_r))]
                               : buf_mem[ptr_r];
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ptr_r <= 9'h000;
         pg_r  <= 9'h000;
      end else if (addr_last) begin
         pg_r  <= page_of(addr_full, mode_q[1]);
         ptr_r <= offset_of(addr_full, mode_q[1]);
      end else if (wr_byte || load_tx) begin
         // Same page and same buffer: no carry into the page number
         ptr_r <= next_off(ptr_r, mode_q[1]);
      end
   end
   always_ff @(posedge ref_clk) begin
      if (wr_byte) begin
         buf_mem[ptr_r] <= sh_nxt;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tx_r      <= 8'h00;
         spi.so    <= 1'b0;
         spi.so_oe <= 1'b0;
      end else begin
         spi.so_oe <= rd_phase;
         if (load_tx) begin
            spi.so <= rd_byte[7];
            tx_r   <= {rd_byte[6:0], 1'b0};
         end else if (sck_fall && rd_phase) begin
            spi.so <= tx_r[7];
            tx_r   <= {tx_r[6:0], 1'b0};
         end
      end
   end
   // ****************************************
   // Self-timed program and erase engine
   // ****************************************
   sfb_eng_e   eng_r;
   logic [7:0] eop_r;
   logic [8:0] epg_r;
   logic [11:0] eidx_r;
   logic [11:0] espan_r;
   logic [15:0] wait_r;
   logic       go;
   logic       op_erase;
   logic       op_prog;
   assign op_erase = op_r == `SFB_OP_PROG_ERASE || op_r == `SFB_OP_PAGE_ERASE ||
                     op_r == `SFB_OP_BLOCK_ERASE;
   assign op_prog  = op_r == `SFB_OP_PROG_ERASE || op_r == `SFB_OP_PROG_NOERASE;
   // Only a frame that carried all three address bytes starts an operation
   assign go = cs_rise & (byte_idx_r >= `SFB_ADDR_DONE) & (op_erase | op_prog) &
               (eng_r == SFB_ENG_IDLE);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         eng_r   <= SFB_ENG_IDLE;
         eop_r   <= 8'h00;
         epg_r   <= 9'h000;
         eidx_r  <= 12'h000;
         espan_r <= 12'h000;
         wait_r  <= 16'h0000;
      end else begin
         unique case (eng_r)
            SFB_ENG_IDLE: begin
               if (go) begin
                  eop_r  <= op_r;
                  eidx_r <= 12'h000;
                  if (op_r == `SFB_OP_BLOCK_ERASE) begin
                     epg_r   <= {pg_r[8:3], 3'h0};
                     espan_r <= 12'(`SFB_BLOCK_PAGES * PAGE_BYTES);
                  end else begin
                     epg_r   <= pg_r;
                     espan_r <= 12'(PAGE_BYTES);
                  end
                  eng_r <= op_erase ? SFB_ENG_ERASE : SFB_ENG_PROG;
               end
            end
            SFB_ENG_ERASE: begin
               eidx_r <= eidx_r + 12'h001;
               if (eidx_r == espan_r - 12'h001) begin
                  eidx_r <= 12'h000;
                  if (eop_r == `SFB_OP_PROG_ERASE) begin
                     eng_r <= SFB_ENG_PROG;
                  end else begin
                     eng_r  <= SFB_ENG_WAIT;
                     wait_r <= (eop_r == `SFB_OP_BLOCK_ERASE) ? 16'(BE_CYC) : 16'(PE_CYC);
                  end
               end
            end
            SFB_ENG_PROG: begin
               eidx_r <= eidx_r + 12'h001;
               if (eidx_r == espan_r - 12'h001) begin
                  eng_r  <= SFB_ENG_WAIT;
                  wait_r <= (eop_r == `SFB_OP_PROG_ERASE) ? 16'(EP_CYC) : 16'(P_CYC);
               end
            end
            SFB_ENG_WAIT: begin
               wait_r <= wait_r - 16'h0001;
               if (wait_r <= 16'h0001) begin
                  eng_r <= SFB_ENG_IDLE;
               end
            end
            default: eng_r <= SFB_ENG_IDLE;
         endcase
      end
   end
   always_ff @(posedge ref_clk) begin
      if (eng_r == SFB_ENG_ERASE) begin
         arr_mem[mem_idx(epg_r, int'(eidx_r))] <= `SFB_ERASED;
      end else if (eng_r == SFB_ENG_PROG) begin
         // Programming only clears bits, so an unerased page ends up ANDed
         arr_mem[mem_idx(epg_r, int'(eidx_r))] <=
            arr_mem[mem_idx(epg_r, int'(eidx_r))] & buf_mem[eidx_r[8:0]];
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
      end else begin
         busy <= go | (eng_r != SFB_ENG_IDLE && !(eng_r == SFB_ENG_WAIT &&
                 wait_r <= 16'h0001));
      end
   end
endmodule // sfb_flash_dev
`default_nettype wire

/* File: include/sfb_map.svh */
`ifndef SFB_MAP_SVH
`define SFB_MAP_SVH
// ****************************************
// Command codes
// ****************************************
`define SFB_OP_PAGE_READ      8'hd2
`define SFB_OP_BUF_READ_FAST  8'hd4
`define SFB_OP_BUF_READ_SLOW  8'hd1
`define SFB_OP_BUF_WRITE      8'h84
`define SFB_OP_PROG_ERASE     8'h83
`define SFB_OP_PROG_NOERASE   8'h88
`define SFB_OP_PAGE_ERASE     8'h81
`define SFB_OP_BLOCK_ERASE    8'h50
// ****************************************
// Frame layout, counted in bytes from the opcode
// ****************************************
`define SFB_ADDR_DONE         4'h4
`define SFB_PR_DATA           4'h8
`define SFB_BR_DATA           4'h5
`define SFB_PR_DUMMY          17'h4
`define SFB_BR_DUMMY          17'h1
`define SFB_HDR_BYTES         17'h4
// ****************************************
// Array geometry and values
// ****************************************
`define SFB_PAGES             512
`define SFB_PAGE_BYTES        264
`define SFB_BLOCK_PAGES       8
`define SFB_BIN_LAST          9'h0ff
`define SFB_ERASED            8'hff
`define SFB_DUMMY_BYTE        8'h00
`define SFB_IDLE_BYTE         8'hff
// ****************************************
// Timing, nanoseconds and derived cycles
// ****************************************
`define SFB_CLK_NS                50
`define SFB_ERASE_PROGRAM_TIME_NS 20000
`define SFB_PROGRAM_TIME_NS       10000
`define SFB_PAGE_ERASE_TIME_NS    15000
`define SFB_BLOCK_ERASE_TIME_NS   40000
`define SFB_EP_CYC  (`SFB_ERASE_PROGRAM_TIME_NS / `SFB_CLK_NS)
`define SFB_P_CYC   (`SFB_PROGRAM_TIME_NS / `SFB_CLK_NS)
`define SFB_PE_CYC  (`SFB_PAGE_ERASE_TIME_NS / `SFB_CLK_NS)
`define SFB_BE_CYC  (`SFB_BLOCK_ERASE_TIME_NS / `SFB_CLK_NS)
`define SFB_SCK_HALF              4
`endif

/* File: include/sfb_pkg.sv */
`default_nettype none
package sfb_pkg;
   typedef logic [7:0] sfb_byte_t;
   typedef enum logic [3:0] {
      SFB_ENG_IDLE  = 4'h1,
      SFB_ENG_ERASE = 4'h2,
      SFB_ENG_PROG  = 4'h4,
      SFB_ENG_WAIT  = 4'h8
   } sfb_eng_e;
   typedef enum logic [2:0] {
      SFB_HST_IDLE  = 3'h1,
      SFB_HST_SHIFT = 3'h2,
      SFB_HST_GAP   = 3'h4
   } sfb_hst_e;
endpackage
`default_nettype wire

/* File: include/sfb_spi_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sfb_spi_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe;
   logic so_pin;
   // Released line reads as pulled up
   assign so_pin = so_oe ? so : 1'b1;
   modport dev  (input cs_n, input sck, input si, output so, output so_oe);
   modport host (output cs_n, output sck, output si, input so_pin);
endinterface
`default_nettype wire

/* File: hw/sfb_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfb_map.svh"
module sfb_spi_host
   import sfb_pkg::*;
#(
   parameter int HALF = `SFB_SCK_HALF
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   sfb_spi_if.host          spi,
   input  wire logic        start,
   input  wire logic [7:0]  opcode,
   input  wire logic [23:0] addr,
   input  wire logic [15:0] len,
   input  wire logic [7:0]  tx_data,
   output logic             tx_take,
   output logic [7:0]       rx_data,
   output logic             rx_valid,
   output logic             done,
   output logic             active
);
   generate
      if (HALF < 4 || HALF > 255) begin : g_bad
         $error("sfb_spi_host: HALF out of range");
      end
   endgenerate
   // ****************************************
   // Frame bookkeeping
   // ****************************************
   logic [1:0]  so_q;
   sfb_hst_e    st_r;
   logic [7:0]  half_r;
   logic [2:0]  bit_r;
   logic [16:0] byte_r;
   logic [16:0] last_r;
   logic [16:0] data0_r;
   logic [7:0]  op_r;
   logic [23:0] addr_r;
   logic [7:0]  tx_r;
   logic [7:0]  rx_sh_r;
   logic        tick;
   logic [16:0] nidx;
   logic [7:0]  nbyte;
   logic        is_rd;
   logic        is_wr;
   logic [16:0] dummies;
   always_comb begin
      unique case (opcode)
         `SFB_OP_PAGE_READ:                            dummies = `SFB_PR_DUMMY;
         `SFB_OP_BUF_READ_FAST, `SFB_OP_BUF_READ_SLOW: dummies = `SFB_BR_DUMMY;
         default:                                      dummies = 17'h0;
      endcase
   end
   assign is_rd = op_r == `SFB_OP_PAGE_READ || op_r == `SFB_OP_BUF_READ_FAST ||
                  op_r == `SFB_OP_BUF_READ_SLOW;
   assign is_wr = op_r == `SFB_OP_BUF_WRITE;
   assign tick  = (st_r != SFB_HST_IDLE) && (half_r == 8'(HALF - 1));
   assign nidx  = byte_r + 17'h1;
   always_comb begin
      nbyte = `SFB_IDLE_BYTE;
      if (nidx == 17'h1) begin
         nbyte = addr_r[23:16];
      end else if (nidx == 17'h2) begin
         nbyte = addr_r[15:8];
      end else if (nidx == 17'h3) begin
         nbyte = addr_r[7:0];
      end else if (nidx < data0_r) begin
         nbyte = `SFB_DUMMY_BYTE;
      end else if (is_wr) begin
         nbyte = tx_data;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         so_q <= 2'h3;
      end else begin
         so_q <= {so_q[0], spi.so_pin};
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         half_r <= 8'h00;
      end else if (st_r == SFB_HST_IDLE || tick) begin
         half_r <= 8'h00;
      end else begin
         half_r <= half_r + 8'h01;
      end
   end
   // ****************************************
   // Pin sequencer, clock idles low
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r     <= SFB_HST_IDLE;
         spi.cs_n <= 1'b1;
         spi.sck  <= 1'b0;
         spi.si   <= 1'b0;
         bit_r    <= 3'h0;
         byte_r   <= 17'h0;
         last_r   <= 17'h0;
         data0_r  <= 17'h0;
         op_r     <= 8'h00;
         addr_r   <= 24'h000000;
         tx_r     <= 8'h00;
         rx_sh_r  <= 8'h00;
         rx_data  <= 8'h00;
         rx_valid <= 1'b0;
         tx_take  <= 1'b0;
         done     <= 1'b0;
         active   <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         tx_take  <= 1'b0;
         done     <= 1'b0;
         unique case (st_r)
            SFB_HST_IDLE: begin
               if (start) begin
                  st_r     <= SFB_HST_SHIFT;
                  active   <= 1'b1;
                  op_r     <= opcode;
                  addr_r   <= addr;
                  data0_r  <= `SFB_HDR_BYTES + dummies;
                  last_r   <= `SFB_HDR_BYTES + dummies + {1'b0, len} - 17'h1;
                  byte_r   <= 17'h0;
                  bit_r    <= 3'h0;
                  spi.cs_n <= 1'b0;
                  spi.si   <= opcode[7];
                  tx_r     <= {opcode[6:0], 1'b0};
               end
            end
            SFB_HST_SHIFT: begin
               if (tick && !spi.sck) begin
                  spi.sck <= 1'b1;
               end else if (tick) begin
                  // Sample just before the falling edge to cover the device's sync delay
                  spi.sck <= 1'b0;
                  rx_sh_r <= {rx_sh_r[6:0], so_q[1]};
                  bit_r   <= bit_r + 3'h1;
                  if (bit_r != 3'h7) begin
                     spi.si <= tx_r[7];
                     tx_r   <= {tx_r[6:0], 1'b0};
                  end else begin
                     if (is_rd && byte_r >= data0_r) begin
                        rx_data  <= {rx_sh_r[6:0], so_q[1]};
                        rx_valid <= 1'b1;
                     end
                     if (byte_r == last_r) begin
                        st_r     <= SFB_HST_GAP;
                        spi.cs_n <= 1'b1;
                     end else begin
                        byte_r  <= nidx;
                        spi.si  <= nbyte[7];
                        tx_r    <= {nbyte[6:0], 1'b0};
                        tx_take <= is_wr && nidx >= data0_r;
                     end
                  end
               end
            end
            SFB_HST_GAP: begin
               if (tick) begin
                  st_r   <= SFB_HST_IDLE;
                  active <= 1'b0;
                  done   <= 1'b1;
               end
            end
            default: st_r <= SFB_HST_IDLE;
         endcase
      end
   end
endmodule // sfb_spi_host
`default_nettype wire

/* File: sim/sfb_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sfb_checker
   import sfb_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe,
   input wire logic busy
);
   // ****************
   // Link checks
   // ****************
   // Longest run is a block erase with shortened wait counts
   localparam int BUSY_MAX = 2400;
   int busy_cnt_r;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busy_cnt_r <= 0;
      end else begin
         busy_cnt_r <= busy ? busy_cnt_r + 1 : 0;
      end
   end
   chk_oe_release: assert property ($rose(cs_n) |-> ##[1:5] !so_oe)
      else $error("so_oe still high after select rose");
   chk_oe_idle: assert property (cs_n [*6] |-> !so_oe)
      else $error("so_oe high between frames");
   chk_oe_frame: assert property ($rose(so_oe) |-> !cs_n)
      else $error("so_oe rose outside a frame");
   chk_so_shift: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck)
      else $error("so changed while sck high");
   chk_si_shift: assert property (!cs_n && $changed(si) |-> !sck)
      else $error("si changed while sck high");
   chk_sck_idle: assert property (cs_n && $past(cs_n) |-> !sck)
      else $error("sck not idle low between frames");
   chk_busy_hold: assert property ($rose(busy) |=> busy [*8])
      else $error("busy dropped too early");
   chk_busy_bound: assert property (busy_cnt_r < BUSY_MAX)
      else $error("busy never ended");
   cover property ($rose(busy));
   cover property ($fell(busy));
   cover property ($rose(so_oe));
endmodule // sfb_checker
`default_nettype wire

/* File: sim/sfb_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sfb_tb_top
   import sfb_pkg::*;
;
   // ****************
   // Bench
   // ****************
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        page_256 = 1'b0;
   logic        start = 1'b0;
   logic [7:0]  opcode = 8'h00;
   logic [23:0] addr = 24'h000000;
   logic [15:0] len = 16'h0000;
   logic [7:0]  tx_data = 8'h00;
   logic [7:0]  rx_data;
   logic        busy, tx_take, rx_valid, done, active;
   sfb_byte_t   wq[$], rq[$], eq[$];
   sfb_byte_t   aq[$] = '{8'h3c, 8'ha5, 8'h0f, 8'h96};
   sfb_byte_t   bq[$] = '{8'hf0, 8'h5a, 8'hff, 8'h00};
   sfb_byte_t   fq[$] = '{8'hff, 8'hff, 8'hff, 8'hff};
   int          errors = 0;
   int          n_compared = 0;
   int          wi = 0;

   sfb_spi_if u_if ();
   sfb_flash_dev #(.EP_CYC(4), .P_CYC(4), .PE_CYC(4), .BE_CYC(4)) u_sfb_flash_dev (
      .ref_clk(ref_clk), .rst(rst), .page_256(page_256), .spi(u_if.dev), .busy(busy));
   sfb_spi_host u_sfb_spi_host (
      .ref_clk(ref_clk), .rst(rst), .spi(u_if.host), .start(start), .opcode(opcode),
      .addr(addr), .len(len), .tx_data(tx_data), .tx_take(tx_take), .rx_data(rx_data),
      .rx_valid(rx_valid), .done(done), .active(active));
   sfb_checker u_chk (
      .ref_clk(ref_clk), .rst(rst), .cs_n(u_if.cs_n), .sck(u_if.sck), .si(u_if.si),
      .so(u_if.so), .so_oe(u_if.so_oe), .busy(busy));

   always #25 ref_clk = ~ref_clk;

   // Next write byte is staged as soon as one is taken, well before the boundary
   always @(posedge ref_clk) begin
      if (start) begin
         wi <= 0;
         tx_data <= (wq.size() > 0) ? wq[0] : 8'h00;
      end else if (tx_take) begin
         wi <= wi + 1;
         tx_data <= (wi + 1 < wq.size()) ? wq[wi + 1] : 8'h00;
      end
      if (rx_valid) begin
         rq.push_back(rx_data);
      end
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_rx(input sfb_byte_t e[$]);
      chk("rx_count", 8'(e.size()), 8'(rq.size()));
      foreach (e[i]) begin
         chk("rx_data", e[i], rq[i]);
      end
   endtask

   task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n);
      int k;
      @(posedge ref_clk);
      rq.delete();
      opcode <= op;
      addr <= a;
      len <= n[15:0];
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      @(negedge ref_clk);
      chk("active", 8'h01, {7'h00, active});
      k = 0;
      do begin
         @(negedge ref_clk);
         k++;
      end while (done !== 1'b1 && k < 1000);
      chk("done", 8'h01, {7'h00, done});
      chk("active", 8'h00, {7'h00, active});
      repeat (2) @(negedge ref_clk);
      chk("so_oe", 8'h00, {7'h00, u_if.so_oe});
   endtask

   task automatic prog(input logic [7:0] op, input logic [23:0] a);
      int k;
      wq.delete();
      cmd(op, a, 0);
      @(negedge ref_clk);
      chk("busy", 8'h01, {7'h00, busy});
      k = 0;
      while (busy !== 1'b0 && k < 3000) begin
         @(negedge ref_clk);
         k++;
      end
      chk("busy", 8'h00, {7'h00, busy});
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic t_erase;
      prog(8'h81, 24'h000a00);
      cmd(8'hd2, 24'h000b06, 4);
      cmp_rx(fq);
   endtask

   task automatic t_buffer;
      wq = aq;
      cmd(8'h84, 24'h000106, 4);
      cmd(8'hd4, 24'h000106, 4);
      cmp_rx(aq);
      cmd(8'hd1, 24'h000106, 4);
      cmp_rx(aq);
   endtask

   // Plain program onto a used page shows that no erase took place
   task automatic t_program;
      prog(8'h83, 24'h000a00);
      cmd(8'hd2, 24'h000b06, 4);
      cmp_rx(aq);
      cmd(8'hd4, 24'h000106, 4);
      cmp_rx(aq);
      wq = bq;
      cmd(8'h84, 24'h000106, 4);
      prog(8'h88, 24'h000a00);
      eq.delete();
      foreach (aq[i]) begin
         eq.push_back(aq[i] & bq[i]);
      end
      cmd(8'hd2, 24'h000b06, 4);
      cmp_rx(eq);
      prog(8'h83, 24'h000a00);
      cmd(8'hd2, 24'h000b06, 4);
      cmp_rx(bq);
      // Erase first, then a plain program must land the buffer unchanged
      prog(8'h81, 24'h000a00);
      prog(8'h88, 24'h000a00);
      cmd(8'hd2, 24'h000b06, 4);
      cmp_rx(bq);
   endtask

   task automatic t_block;
      prog(8'h50, 24'h000e00);
      cmd(8'hd2, 24'h000b06, 4);
      cmp_rx(fq);
   endtask

   task automatic t_binary;
      @(posedge ref_clk);
      page_256 <= 1'b1;
      repeat (4) @(posedge ref_clk);
      wq = '{8'h11, 8'h22};
      cmd(8'h84, 24'h0000ff, 2);
      cmd(8'hd4, 24'h0000ff, 2);
      cmp_rx(wq);
   endtask

   task automatic test_done;
      if (errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      t_erase();
      t_buffer();
      t_program();
      t_block();
      t_binary();
      test_done();
   end

   initial begin
      #3000000;
      errors++;
      test_done();
   end
endmodule // sfb_tb_top
`default_nettype wire
